// [src/ttm_mode_ctrl.sv]
// Functional notes
// R01 - Non-record modes latch from one button press, acting when it ends; stop here acts when its press begins.
// R02 - Record needs record held, run pressed and released, then record up.
// R03 - Stop halts all motion any time; transport waits in standby.
// R04 - Stop at top speed refuses run and record for five seconds.
// R05 - Fast modes still start normally during that stop lockout.
// R06 - Direct mode changes allowed; settling delays keep tape safe.
// R07 - Ready output stays on while transport is operable, every mode.
// R08 - Speed changes during motion wait four seconds before reached.
// R09 - Fast forward straight to fast reverse waits twelve seconds.
// R10 - Remote selector hands the five mode commands to remote inputs.
// R11 - Phase lock on tape takes capstan reference from recorded channel.
// R12 - Lost recorded reference falls back to sine and lights indicator.
// R13 - End sense switch on lets photo sensors stop tape; off ignores.
// R14 - Photo end sense while recording closes the transfer contact.
// R15 - Transfer direction off ignores incoming transfer closures.
// R16 - Incoming closure starts record reverse or forward per switch.
// R17 - Each unit both sends and receives the transfer command.
// R18 - Record test lights record lamp, enables bias, refuses motion.
// R19 - Established mode lights its button lamp through lock-up output.
// R20 - Lost tension brakes and stops; nothing starts without tension.
// R21 - Inputs filtered; one motion mode at a time, newest replaces.
// R22 - Lockout and settling timed by clock counters, set at elaboration.
//
// Design decisions made here: the register offsets and the APB slave port.
`timescale 1ns/10ps
module ttm_mode_ctrl
	import ttm_pkg::*;
#(
	parameter int unsigned STOP_LOCK = STOP_LOCK_CYC,
	parameter int unsigned SETTLE    = SETTLE_CYC,
	parameter int unsigned REV_SET   = REV_SET_CYC,
	parameter int unsigned DB_CYC    = DEBOUNCE_CYC
) (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              rst,
	// APB slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	// Local panel buttons, high while pressed
	input  wire logic              btn_run_fwd,
	input  wire logic              btn_run_rev,
	input  wire logic              btn_fast_fwd,
	input  wire logic              btn_fast_rev,
	input  wire logic              btn_stop,
	input  wire logic              btn_record,
	// Remote station commands, same order as local
	input  wire logic [4:0]        remote_cmd,
	// Selectors and switches
	input  wire logic [SPEED_W-1:0] speed_sel,
	input  wire logic              remote_selector_position,
	input  wire logic              record_test_selector,
	input  wire logic              end_sense_defeat_switch,
	input  wire logic [1:0]        transfer_direction_switch,
	input  wire logic              phase_lock_tape,
	// Sensors
	input  wire logic              tape_tension_ok,
	input  wire logic              photo_end_sense,
	input  wire logic              ref_signal_present,
	input  wire logic              transfer_in,
	// Transport drive
	output logic                   tape_fwd,
	output logic                   tape_rev,
	output logic                   tape_fast,
	output logic                   pinch_roller,
	output logic                   brake_apply,
	output logic                   record_enable,
	// Panel indicators
	output logic                   record_lamp,
	output logic                   record_bias,
	output logic [LAMP_W-1:0]      lockup_lamp,
	output logic                   ready,
	output logic                   speed_reached,
	output logic                   capstan_ref_tape,
	output logic                   fallback_reference_indicator,
	// Transfer contact toward the other transport
	output logic                   transfer_terminal_block
);

	typedef struct packed {
		ttm_mode_t                 mode;
		logic                      rec_seen;
		logic                      rec_rev;
		logic [CNT_W-1:0]          lock_cnt;
		logic [CNT_W-1:0]          settle_cnt;
		logic [SPEED_W-1:0]        speed_prev;
		logic                      inhibit;
		logic [31:0]               prdata;
		logic                      pready;
		logic                      pslverr;
		logic                      tape_fwd;
		logic                      tape_rev;
		logic                      tape_fast;
		logic                      pinch;
		logic                      brake;
		logic                      rec_en;
		logic                      rec_lamp;
		logic                      rec_bias;
		logic [LAMP_W-1:0]         lamp;
		logic                      ready;
		logic                      reached;
		logic                      cap_tape;
		logic                      fallback;
		logic                      xfer;
	} ttm_state_t;

	ttm_state_t s_r;
	ttm_state_t s_nxt;

	// ==========================================================
	// Input filtering
	ttm_btn_if btn ();

	assign btn.raw = {photo_end_sense, transfer_in, remote_cmd,
		btn_record, btn_stop, btn_fast_rev, btn_fast_fwd,
		btn_run_rev, btn_run_fwd};

	ttm_debounce #(
		.DB_CYC (DB_CYC)
	) u_debounce (
		.clk (clk),
		.rst (rst),
		.btn (btn)
	);

	// ==========================================================
	// Mode control
	logic [4:0]  cmd_fall;
	logic        cmd_stop;
	logic        sw_stop;
	logic        wr_ctrl;
	logic        moving;
	logic        halt;
	logic        req_v;
	ttm_mode_t   req_mode;
	logic        blocked;
	logic [31:0] status;

	always_comb begin
		s_nxt         = s_r;
		s_nxt.lock_cnt   = ttm_dec(s_r.lock_cnt); // R22
		s_nxt.settle_cnt = ttm_dec(s_r.settle_cnt);
		req_v         = 1'b0;
		req_mode      = MODE_STOP;
		wr_ctrl       = psel & penable & s_r.pready & pwrite &
			(paddr == REG_CTRL);
		sw_stop       = wr_ctrl & pwdata[CTRL_STOP_BIT];
		moving        = (s_r.mode != MODE_STOP);

		// Command source follows the remote selector
		if (remote_selector_position) begin
			cmd_fall = btn.fall[IN_REMOTE +: 5]; // R10
			cmd_stop = btn.rise[IN_REMOTE + IN_STOP];
		end else begin
			cmd_fall = btn.fall[IN_STOP:IN_RUN_FWD];
			cmd_stop = btn.rise[IN_STOP];
		end

		// Record double action, local panel only
		if (remote_selector_position) begin
			s_nxt.rec_seen = 1'b0;
		end else begin
			if (btn.rise[IN_RECORD]) begin
				s_nxt.rec_seen = 1'b0; // R02
			end
			if (btn.level[IN_RECORD] && cmd_fall[IN_RUN_FWD]) begin
				s_nxt.rec_seen = 1'b1; // R02
				s_nxt.rec_rev  = 1'b0;
			end
			if (btn.level[IN_RECORD] && cmd_fall[IN_RUN_REV]) begin
				s_nxt.rec_seen = 1'b1; // R02
				s_nxt.rec_rev  = 1'b1;
			end
			if (btn.fall[IN_RECORD]) begin
				s_nxt.rec_seen = 1'b0;
				if (s_r.rec_seen) begin
					req_v    = 1'b1; // R02
					req_mode = s_r.rec_rev ? MODE_REC_REV : MODE_REC_FWD;
				end
			end
		end

		// Single-press modes; run presses under held record are eaten
		if (!req_v) begin
			if (cmd_fall[IN_FAST_REV]) begin
				req_v    = 1'b1; // R01
				req_mode = MODE_FAST_REV;
			end else if (cmd_fall[IN_FAST_FWD]) begin
				req_v    = 1'b1; // R01
				req_mode = MODE_FAST_FWD;
			end else if (!btn.level[IN_RECORD] ||
				remote_selector_position) begin
				if (cmd_fall[IN_RUN_REV]) begin
					req_v    = 1'b1; // R01
					req_mode = MODE_RUN_REV;
				end else if (cmd_fall[IN_RUN_FWD]) begin
					req_v    = 1'b1; // R01
					req_mode = MODE_RUN_FWD;
				end
			end
		end

		// Transfer closure from the other transport
		if (!req_v && btn.rise[IN_XFER]) begin
			if (transfer_direction_switch == XDIR_REV) begin
				req_v    = 1'b1; // R16
				req_mode = MODE_REC_REV;
			end else if (transfer_direction_switch == XDIR_FWD) begin
				req_v    = 1'b1; // R16
				req_mode = MODE_REC_FWD;
			end
			// Switch off: closure ignored R15
		end

		// Any cause that must bring tape to rest
		halt = cmd_stop | sw_stop; // R03
		if (!tape_tension_ok || record_test_selector || s_r.inhibit) begin
			halt = 1'b1; // R20 R18
		end
		if (end_sense_defeat_switch && btn.rise[IN_PHOTO]) begin
			halt = 1'b1; // R13
		end

		// Run and record refused while the stop lockout runs
		blocked = (s_r.lock_cnt != '0) && (req_mode == MODE_RUN_FWD ||
			req_mode == MODE_RUN_REV || req_mode == MODE_REC_FWD ||
			req_mode == MODE_REC_REV); // R04 R05

		if (halt) begin
			s_nxt.mode = MODE_STOP; // R03
			if (moving && s_r.speed_prev == SPEED_HIGH) begin
				s_nxt.lock_cnt = CNT_W'(STOP_LOCK); // R04
			end
			if (moving) begin
				s_nxt.xfer = 1'b0;
			end
		end else if (req_v && !blocked) begin
			s_nxt.mode = req_mode; // R21 R06
			s_nxt.xfer = 1'b0;
			if (s_r.mode == MODE_FAST_FWD && req_mode == MODE_FAST_REV) begin
				s_nxt.settle_cnt = CNT_W'(REV_SET); // R09
			end
		end

		// Speed changes under way need settling time
		s_nxt.speed_prev = speed_sel;
		if (moving && speed_sel != s_r.speed_prev &&
			s_nxt.settle_cnt < CNT_W'(SETTLE)) begin
			s_nxt.settle_cnt = CNT_W'(SETTLE); // R08
		end
		if (s_nxt.mode == MODE_STOP) begin
			s_nxt.settle_cnt = '0;
		end

		// Transfer contact closes on end sense while recording
		if ((s_r.mode == MODE_REC_FWD || s_r.mode == MODE_REC_REV) &&
			btn.rise[IN_PHOTO]) begin
			s_nxt.xfer = 1'b1; // R14 R17
		end

		// Drive and lamp outputs from the next mode
		s_nxt.tape_fwd  = (s_nxt.mode == MODE_RUN_FWD) ||
			(s_nxt.mode == MODE_FAST_FWD) || (s_nxt.mode == MODE_REC_FWD);
		s_nxt.tape_rev  = (s_nxt.mode == MODE_RUN_REV) ||
			(s_nxt.mode == MODE_FAST_REV) || (s_nxt.mode == MODE_REC_REV);
		s_nxt.tape_fast = (s_nxt.mode == MODE_FAST_FWD) ||
			(s_nxt.mode == MODE_FAST_REV);
		s_nxt.pinch     = (s_nxt.mode != MODE_STOP) && !s_nxt.tape_fast;
		s_nxt.brake     = (s_nxt.mode == MODE_STOP); // R20
		s_nxt.rec_en    = (s_nxt.mode == MODE_REC_FWD) ||
			(s_nxt.mode == MODE_REC_REV);
		s_nxt.rec_lamp  = s_nxt.rec_en | record_test_selector; // R18
		s_nxt.rec_bias  = s_nxt.rec_en | record_test_selector; // R18
		s_nxt.lamp      = '0;
		unique case (s_nxt.mode)
			MODE_STOP:     s_nxt.lamp[LAMP_STOP] = 1'b1; // R19
			MODE_RUN_FWD:  s_nxt.lamp[IN_RUN_FWD] = 1'b1;
			MODE_RUN_REV:  s_nxt.lamp[IN_RUN_REV] = 1'b1;
			MODE_FAST_FWD: s_nxt.lamp[IN_FAST_FWD] = 1'b1;
			MODE_FAST_REV: s_nxt.lamp[IN_FAST_REV] = 1'b1;
			MODE_REC_FWD: begin
				s_nxt.lamp[IN_RUN_FWD]  = 1'b1;
				s_nxt.lamp[LAMP_RECORD] = 1'b1;
			end
			MODE_REC_REV: begin
				s_nxt.lamp[IN_RUN_REV]  = 1'b1;
				s_nxt.lamp[LAMP_RECORD] = 1'b1;
			end
			default: s_nxt.lamp = '0;
		endcase
		s_nxt.ready    = tape_tension_ok; // R07
		s_nxt.reached  = (s_nxt.mode != MODE_STOP) &&
			(s_nxt.settle_cnt == '0);
		s_nxt.cap_tape = phase_lock_tape & ref_signal_present; // R11
		s_nxt.fallback = phase_lock_tape & ~ref_signal_present; // R12

		// Register bus: one-cycle access, zero wait states
		if (wr_ctrl) begin
			s_nxt.inhibit = pwdata[CTRL_INHIB_BIT];
		end
		status = '0;
		status[ST_MODE_LSB +: 3] = s_r.mode;
		status[ST_LOCK_BIT]      = (s_r.lock_cnt != '0);
		status[ST_SETTLE_BIT]    = (s_r.settle_cnt != '0);
		status[ST_REACHED_BIT]   = s_r.reached;
		status[ST_FALLBACK_BIT]  = s_r.fallback;
		status[ST_XFER_BIT]      = s_r.xfer;
		status[ST_READY_BIT]     = s_r.ready;
		status[ST_TEST_BIT]      = record_test_selector;
		status[ST_INHIB_BIT]     = s_r.inhibit;
		s_nxt.pready  = psel & ~penable;
		s_nxt.pslverr = 1'b0;
		s_nxt.prdata  = '0;
		if (psel && !penable) begin
			if (paddr == REG_CTRL) begin
				s_nxt.prdata[CTRL_INHIB_BIT] = s_r.inhibit;
			end else if (paddr == REG_STATUS) begin
				s_nxt.prdata = status;
			end else begin
				s_nxt.pslverr = 1'b1; // Unmapped address
			end
		end
	end

	// State register
	always_ff @(posedge clk) begin
		if (rst) begin
			s_r         <= '0;
			s_r.mode    <= MODE_STOP;
			s_r.inhibit <= CTRL_INHIB_RST;
			s_r.brake   <= 1'b1;
			s_r.lamp    <= LAMP_W'(1) << LAMP_STOP;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ==========================================================
	// Outputs straight from the state register
	assign prdata                       = s_r.prdata;
	assign pready                       = s_r.pready;
	assign pslverr                      = s_r.pslverr;
	assign tape_fwd                     = s_r.tape_fwd;
	assign tape_rev                     = s_r.tape_rev;
	assign tape_fast                    = s_r.tape_fast;
	assign pinch_roller                 = s_r.pinch;
	assign brake_apply                  = s_r.brake;
	assign record_enable                = s_r.rec_en;
	assign record_lamp                  = s_r.rec_lamp;
	assign record_bias                  = s_r.rec_bias;
	assign lockup_lamp                  = s_r.lamp;
	assign ready                        = s_r.ready;
	assign speed_reached                = s_r.reached;
	assign capstan_ref_tape             = s_r.cap_tape;
	assign fallback_reference_indicator = s_r.fallback;
	assign transfer_terminal_block      = s_r.xfer;

endmodule : ttm_mode_ctrl

// [src/ttm_pkg.sv]
package ttm_pkg;

	// ==========================================================
	// Timing
	localparam int unsigned CLK_HZ        = 10_000_000;
	localparam int unsigned STOP_LOCK_S   = 5;
	localparam int unsigned SETTLE_S      = 4;
	localparam int unsigned REV_SETTLE_S  = 12;
	localparam int unsigned DEBOUNCE_MS   = 10;
	localparam int unsigned STOP_LOCK_CYC = STOP_LOCK_S * CLK_HZ;
	localparam int unsigned SETTLE_CYC    = SETTLE_S * CLK_HZ;
	localparam int unsigned REV_SET_CYC   = REV_SETTLE_S * CLK_HZ;
	localparam int unsigned DEBOUNCE_CYC  = DEBOUNCE_MS * (CLK_HZ / 1000);
	localparam int unsigned CNT_W         = 27;
	localparam int unsigned DB_W          = 17;

	// ==========================================================
	// Filtered input lanes
	localparam int unsigned IN_RUN_FWD  = 0;
	localparam int unsigned IN_RUN_REV  = 1;
	localparam int unsigned IN_FAST_FWD = 2;
	localparam int unsigned IN_FAST_REV = 3;
	localparam int unsigned IN_STOP     = 4;
	localparam int unsigned IN_RECORD   = 5;
	localparam int unsigned IN_REMOTE   = 6;
	localparam int unsigned IN_XFER     = 11;
	localparam int unsigned IN_PHOTO    = 12;
	localparam int unsigned NUM_IN      = 13;

	// ==========================================================
	// Selector codes
	localparam int unsigned SPEED_W    = 3;
	localparam logic [2:0]  SPEED_LOW  = 3'h0;
	localparam logic [2:0]  SPEED_HIGH = 3'h5;
	localparam logic [1:0]  XDIR_OFF   = 2'h0;
	localparam logic [1:0]  XDIR_REV   = 2'h1;
	localparam logic [1:0]  XDIR_FWD   = 2'h2;

	// ==========================================================
	// Lock-up lamp lanes
	localparam int unsigned LAMP_STOP   = 4;
	localparam int unsigned LAMP_RECORD = 5;
	localparam int unsigned LAMP_W      = 6;

	// ==========================================================
	// Register map
	localparam int unsigned ADDR_W          = 8;
	localparam logic [7:0]  REG_CTRL        = 8'h00;
	localparam logic [7:0]  REG_STATUS      = 8'h04;
	localparam int unsigned CTRL_STOP_BIT   = 0;
	localparam int unsigned CTRL_INHIB_BIT  = 1;
	localparam logic        CTRL_INHIB_RST  = 1'b0;
	localparam int unsigned ST_MODE_LSB     = 0;
	localparam int unsigned ST_LOCK_BIT     = 3;
	localparam int unsigned ST_SETTLE_BIT   = 4;
	localparam int unsigned ST_REACHED_BIT  = 5;
	localparam int unsigned ST_FALLBACK_BIT = 6;
	localparam int unsigned ST_XFER_BIT     = 7;
	localparam int unsigned ST_READY_BIT    = 8;
	localparam int unsigned ST_TEST_BIT     = 9;
	localparam int unsigned ST_INHIB_BIT    = 10;

	// ==========================================================
	// Transport modes
	typedef enum logic [2:0] {
		MODE_STOP,
		MODE_RUN_FWD,
		MODE_RUN_REV,
		MODE_FAST_FWD,
		MODE_FAST_REV,
		MODE_REC_FWD,
		MODE_REC_REV
	} ttm_mode_t;

	// Counter step toward zero, holding at zero
	function automatic logic [CNT_W-1:0] ttm_dec(input logic [CNT_W-1:0] c);
		ttm_dec = (c == '0) ? c : c - CNT_W'(1);
	endfunction : ttm_dec

endpackage : ttm_pkg

// [src/ttm_btn_if.sv]
`timescale 1ns/10ps
interface ttm_btn_if;
	import ttm_pkg::*;
	logic [NUM_IN-1:0] raw;
	logic [NUM_IN-1:0] level;
	logic [NUM_IN-1:0] rise;
	logic [NUM_IN-1:0] fall;
	modport filt (input raw, output level, rise, fall);
	modport user (output raw, input level, rise, fall);
endinterface : ttm_btn_if

// [src/ttm_debounce.sv]
`timescale 1ns/10ps
module ttm_debounce
	import ttm_pkg::*;
#(
	parameter int unsigned DB_CYC = DEBOUNCE_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Raw and filtered lanes
	ttm_btn_if.filt  btn
);

	typedef struct packed {
		logic [NUM_IN-1:0][DB_W-1:0] cnt;
		logic [NUM_IN-1:0]           level;
		logic [NUM_IN-1:0]           rise;
		logic [NUM_IN-1:0]           fall;
	} ttm_db_state_t;

	ttm_db_state_t s_r;
	ttm_db_state_t s_nxt;

	// ==========================================================
	// Level must hold steady for the whole window before it flips
	always_comb begin
		s_nxt      = s_r;
		s_nxt.rise = '0;
		s_nxt.fall = '0;
		for (int i = 0; i < NUM_IN; i++) begin
			if (btn.raw[i] == s_r.level[i]) begin
				s_nxt.cnt[i] = '0;
			end else if (s_r.cnt[i] >= DB_W'(DB_CYC - 1)) begin
				s_nxt.cnt[i]   = '0; // R21
				s_nxt.level[i] = btn.raw[i];
				s_nxt.rise[i]  = btn.raw[i];
				s_nxt.fall[i]  = ~btn.raw[i];
			end else begin
				s_nxt.cnt[i] = s_r.cnt[i] + DB_W'(1);
			end
		end
	end

	// State register
	always_ff @(posedge clk) begin
		if (rst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign btn.level = s_r.level;
	assign btn.rise  = s_r.rise;
	assign btn.fall  = s_r.fall;

endmodule : ttm_debounce

// [tb/ttm_mode_ctrl_checker.sv]
`timescale 1ns/10ps
// ==========================================================
// Port-level checks of the transport controller
module ttm_mode_ctrl_checker
	import ttm_pkg::*;
(
	// Clock and reset
	input wire logic              clk,
	input wire logic              rst,
	// Bus and drive
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pready,
	input wire logic              pslverr,
	input wire logic              tape_fwd,
	input wire logic              tape_rev,
	input wire logic              brake_apply,
	input wire logic              record_enable,
	input wire logic              speed_reached,
	input wire logic              transfer_terminal_block,
	// Panel, selectors and sensors
	input wire logic [LAMP_W-1:0] lockup_lamp,
	input wire logic              ready,
	input wire logic              record_bias,
	input wire logic              tape_tension_ok,
	input wire logic              record_test_selector,
	input wire logic              phase_lock_tape,
	input wire logic              ref_signal_present,
	input wire logic              capstan_ref_tape,
	input wire logic              fallback_reference_indicator
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	logic moving;
	// Any tape motion at all
	assign moving = tape_fwd || tape_rev;
	// Setup cycle, then the answered access cycle
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_answer;
		psel && penable && pready;
	endsequence
	a_reset_state: assert property (disable iff (1'b0)
		rst |=> brake_apply && lockup_lamp == 6'h10 && !moving)
		else $error("reset state wrong");
	a_bus_no_wait: assert property (s_setup |=> s_answer)
		else $error("bus answer missing");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready held too long");
	a_error_with_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_ready_tension: assert property (!$past(rst) |->
		ready == $past(tape_tension_ok))
		else $error("ready not following tension");
	a_dir_exclusive: assert property (!(tape_fwd && tape_rev))
		else $error("both directions driven");
	a_lamp_single: assert property ($onehot(lockup_lamp[4:0]))
		else $error("lock-up lamps not one-hot");
	a_tension_halt: assert property (!tape_tension_ok [*8] |->
		brake_apply && !moving)
		else $error("motion without tension");
	a_test_no_motion: assert property (record_test_selector [*8] |->
		!moving && record_bias)
		else $error("motion in record test");
	a_reached_moving: assert property (speed_reached |-> moving)
		else $error("speed reached while stopped");
	a_xfer_cause: assert property ($rose(transfer_terminal_block) |->
		$past(record_enable))
		else $error("transfer closed outside record");
	a_capstan_ref: assert property (!$past(rst) |->
		capstan_ref_tape == $past(phase_lock_tape && ref_signal_present)
		&& fallback_reference_indicator
		== $past(phase_lock_tape && !ref_signal_present))
		else $error("capstan reference wrong");
endmodule : ttm_mode_ctrl_checker

bind ttm_mode_ctrl ttm_mode_ctrl_checker ttm_mode_ctrl_checker_inst (
	.clk, .rst, .psel, .penable, .pready, .pslverr, .tape_fwd, .tape_rev,
	.brake_apply, .record_enable, .speed_reached, .transfer_terminal_block,
	.lockup_lamp, .ready, .record_bias, .tape_tension_ok,
	.record_test_selector, .phase_lock_tape, .ref_signal_present,
	.capstan_ref_tape, .fallback_reference_indicator
);

// [tb/ttm_panel_model.sv]
`timescale 1ns/10ps
// ==========================================================
// Operator panel and remote station: momentary presses
module ttm_panel_model
	import ttm_pkg::*;
(
	// Clock and request
	input  wire logic       clk,
	input  wire logic       go,
	input  wire logic [2:0] code,
	input  wire logic       remote,
	// Buttons toward the controller
	output logic [5:0]      btn,
	output logic [4:0]      remote_cmd,
	output logic            busy
);
	logic [5:0] cnt_r  = 6'h00;
	logic [2:0] code_r = 3'h0;
	// Step count of one press sequence, restarted by go
	always @(posedge clk) begin
		if (go) begin
			cnt_r  <= 6'h01;
			code_r <= code;
		end else if (cnt_r != 6'h00) begin
			cnt_r <= (cnt_r == 6'h14) ? 6'h00 : cnt_r + 6'h01;
		end
	end
	// Codes 0-4 press one button; 5/6 record with run; 7 record alone
	always_comb begin
		btn        = 6'h00;
		remote_cmd = 5'h00;
		if (code_r >= 3'h5) begin
			btn[IN_RECORD] = (cnt_r >= 6'h01) && (cnt_r <= 6'h10);
			if (code_r != 3'h7)
				btn[code_r - 3'h5] = (cnt_r >= 6'h05) && (cnt_r <= 6'h09);
		end else if (remote) begin
			remote_cmd[code_r] = (cnt_r >= 6'h01) && (cnt_r <= 6'h04);
		end else begin
			btn[code_r] = (cnt_r >= 6'h01) && (cnt_r <= 6'h04);
		end
	end
	assign busy = (cnt_r != 6'h00);
endmodule : ttm_panel_model

// [tb/ttm_mode_ctrl_tb.sv]
`timescale 1ns/10ps
// ==========================================================
// Self-checking bench for the transport controller
module ttm_mode_ctrl_tb
	import ttm_pkg::*;
;
	logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rq;
	logic pready, pslverr, re, busy, go = 0, rmt = 0;
	logic [5:0] btn, lockup_lamp;
	logic [4:0] remote_cmd;
	logic [2:0] code = 0, speed_sel = 3'h2, c;
	logic [1:0] transfer_direction_switch = XDIR_OFF, d;
	logic remote_selector_position = 0, record_test_selector = 0;
	logic end_sense_defeat_switch = 1, phase_lock_tape = 0;
	logic tape_tension_ok = 1, photo_end_sense = 0;
	logic ref_signal_present = 1, transfer_in = 0;
	logic tape_fwd, tape_rev, tape_fast, pinch_roller, brake_apply;
	logic record_enable, record_lamp, record_bias, ready, speed_reached;
	logic capstan_ref_tape, fallback_reference_indicator;
	logic transfer_terminal_block;
	int num_errors = 0, total_checks = 0, cyc = 0, seed = 32'h52c6804b;
	// Short counts keep the run brief
	ttm_mode_ctrl #(.STOP_LOCK(100), .SETTLE(10), .REV_SET(30), .DB_CYC(2))
	ttm_mode_ctrl_inst (.clk, .rst, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .btn_run_fwd(btn[0]),
		.btn_run_rev(btn[1]), .btn_fast_fwd(btn[2]), .btn_fast_rev(btn[3]),
		.btn_stop(btn[4]), .btn_record(btn[5]), .remote_cmd, .speed_sel,
		.remote_selector_position, .record_test_selector,
		.end_sense_defeat_switch, .transfer_direction_switch,
		.phase_lock_tape, .tape_tension_ok, .photo_end_sense,
		.ref_signal_present, .transfer_in, .tape_fwd, .tape_rev, .tape_fast,
		.pinch_roller, .brake_apply, .record_enable, .record_lamp,
		.record_bias, .lockup_lamp, .ready, .speed_reached,
		.capstan_ref_tape, .fallback_reference_indicator,
		.transfer_terminal_block);
	ttm_panel_model ttm_panel_model_inst (.clk, .go, .code, .remote(rmt),
		.btn, .remote_cmd, .busy);
	// Clock and hang guard
	initial begin
		forever #50 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			tally_and_finish;
		end
	end
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : tally_and_finish
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : chk
	// One bus transfer, held until pready is seen
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] v);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= v;
		@(posedge clk);
		penable <= 1;
		do @(posedge clk); while (pready !== 1'b1);
		rq = prdata;
		re = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge clk);
	endtask : apb
	// Panel request, then room for the filtered edge to act
	task automatic press(input logic [2:0] k);
		code <= k;
		go <= 1;
		@(posedge clk);
		go <= 0;
		do @(posedge clk); while (busy);
		repeat (6) @(posedge clk);
	endtask : press
	function automatic logic [5:0] lamp_of(input logic [2:0] m);
		lamp_of = (m == 3'h0) ? 6'h10 : (m >= 3'h5) ? {1'b1, 5'(m - 3'h4)}
			: 6'(1 << (m - 3'h1));
	endfunction : lamp_of
	task automatic chk_mode(input logic [2:0] m);
		apb(0, REG_STATUS, 0);
		chk(rq[2:0], m);
		chk(lockup_lamp, lamp_of(m));
	endtask : chk_mode
	initial begin
		repeat (6) @(posedge clk);
		rst <= 0;
		repeat (2) @(posedge clk);
		chk({brake_apply, ready}, 2'h3);
		apb(0, REG_CTRL, 0);
		chk(rq, 32'h0);
		apb(1, REG_CTRL, 32'h2);
		apb(0, REG_CTRL, 0);
		chk(rq, 32'h2);
		press(0);
		chk_mode(0);
		apb(1, REG_CTRL, 0);
		apb(0, 8'h08, 0);
		chk(re, 1);
		chk(rq, 0);
		repeat (8) begin
			c = 3'($unsigned($random(seed)) % 4);
			press(c);
			chk_mode(c + 3'h1);
			chk({tape_fast, tape_rev, tape_fwd, pinch_roller},
				{c[1], c[0], ~c[0], ~c[1]});
		end
		apb(1, REG_CTRL, 32'h1);
		repeat (6) @(posedge clk);
		chk_mode(0);
		press(5);
		chk_mode(5);
		chk(record_enable, 1);
		press(4);
		press(7);
		chk_mode(0);
		press(6);
		chk_mode(6);
		record_test_selector <= 1;
		repeat (10) @(posedge clk);
		chk({record_lamp, record_bias}, 2'h3);
		press(0);
		chk_mode(0);
		record_test_selector <= 0;
		tape_tension_ok <= 0;
		press(0);
		chk({brake_apply, ready}, 2'h2);
		chk_mode(0);
		tape_tension_ok <= 1;
		speed_sel <= SPEED_HIGH;
		press(2);
		press(4);
		apb(0, REG_STATUS, 0);
		chk(rq[ST_LOCK_BIT], 1);
		press(0);
		chk_mode(0);
		press(2);
		chk_mode(3);
		repeat (120) @(posedge clk);
		press(0);
		chk_mode(1);
		speed_sel <= SPEED_LOW;
		repeat (6) @(posedge clk);
		chk(speed_reached, 0);
		repeat (14) @(posedge clk);
		chk(speed_reached, 1);
		press(2);
		press(3);
		chk(speed_reached, 0);
		repeat (20) @(posedge clk);
		chk(speed_reached, 1);
		press(5);
		photo_end_sense <= 1;
		repeat (8) @(posedge clk);
		chk_mode(0);
		chk(transfer_terminal_block, 1);
		photo_end_sense <= 0;
		end_sense_defeat_switch <= 0;
		press(0);
		photo_end_sense <= 1;
		repeat (8) @(posedge clk);
		chk_mode(1);
		chk(transfer_terminal_block, 0);
		photo_end_sense <= 0;
		for (int i = 0; i < 3; i++) begin
			d = 2'(i);
			press(4);
			transfer_direction_switch <= d;
			transfer_in <= 1;
			repeat (8) @(posedge clk);
			transfer_in <= 0;
			repeat (4) @(posedge clk);
			chk_mode((d == XDIR_OFF) ? 3'h0 : 3'h7 - 3'(d));
		end
		remote_selector_position <= 1;
		rmt <= 1;
		press(1);
		chk_mode(2);
		rmt <= 0;
		press(0);
		chk_mode(2);
		rmt <= 1;
		press(4);
		chk_mode(0);
		repeat (8) begin
			phase_lock_tape <= 1'($random(seed));
			ref_signal_present <= 1'($random(seed));
			repeat (2) @(posedge clk);
			chk({capstan_ref_tape, fallback_reference_indicator},
				{phase_lock_tape & ref_signal_present,
				phase_lock_tape & ~ref_signal_present});
		end
		tally_and_finish;
	end
endmodule : ttm_mode_ctrl_tb
